// [design/mdx_defines.vh]
// Constants for the data-move and arithmetic execution unit.
// Assumes inclusion by bare name from the design file.
`ifndef MDX_DEFINES_VH
`define MDX_DEFINES_VH

// Flag register bit positions
`define MDX_FZ   0
`define MDX_FC   1
`define MDX_FAC  2
`define MDX_FOV  3

// Data memory and bit access
`define MDX_RAM_DEPTH    128
`define MDX_BIT_ADDR_MAX 8'h3f

// Register offsets (byte addresses)
`define MDX_REG_WORK   12'h000
`define MDX_REG_FLAG   12'h004
`define MDX_REG_STACK  12'h008
`define MDX_REG_MULOP  12'h00c
`define MDX_REG_MULHI  12'h010
`define MDX_REG_STAT   12'h014
`define MDX_RAM_BASE   3'h1

// Status bit positions
`define MDX_ST_BUSY    0
`define MDX_ST_BITERR  1
`define MDX_ST_OPERR   2

// Reset values
`define MDX_RST_WORK   8'h00
`define MDX_RST_FLAG   4'h0
`define MDX_RST_STACK  8'h00
`define MDX_RST_MULOP  8'h00

// Operation codes
`define MDX_OP_MOV_AI   6'h00
`define MDX_OP_MOV_MA   6'h01
`define MDX_OP_MOV_AM   6'h02
`define MDX_OP_MOV_AIO  6'h03
`define MDX_OP_MOV_IOA  6'h04
`define MDX_OP_TLOAD    6'h05
`define MDX_OP_TSTORE   6'h06
`define MDX_OP_IDX_RD   6'h07
`define MDX_OP_IDX_WR   6'h08
`define MDX_OP_XCH      6'h09
`define MDX_OP_PUSH     6'h0a
`define MDX_OP_POP      6'h0b
`define MDX_OP_ADD_AI   6'h0c
`define MDX_OP_ADD_AM   6'h0d
`define MDX_OP_ADD_MA   6'h0e
`define MDX_OP_ADDC_AM  6'h0f
`define MDX_OP_ADDC_MA  6'h10
`define MDX_OP_ADDC_A   6'h11
`define MDX_OP_ADDC_M   6'h12
`define MDX_OP_NADD_AM  6'h13
`define MDX_OP_NADD_MA  6'h14
`define MDX_OP_SUB_AI   6'h15
`define MDX_OP_SUB_AM   6'h16
`define MDX_OP_SUB_MA   6'h17
`define MDX_OP_SUBC_AM  6'h18
`define MDX_OP_SUBC_MA  6'h19
`define MDX_OP_SUBC_A   6'h1a
`define MDX_OP_SUBC_M   6'h1b
`define MDX_OP_INC_M    6'h1c
`define MDX_OP_DEC_M    6'h1d
`define MDX_OP_CLR_M    6'h1e
`define MDX_OP_MUL      6'h1f
`define MDX_OP_BCLR_M   6'h20
`define MDX_OP_BSET_M   6'h21

`endif

// [design/mdx_exec.v]
// Execution datapath for data moves and arithmetic of an 8-bit core.
// Assumes one clock, a command issuer on the same clock, a Wishbone
// classic master for the registers, and same-clock timer and IO logic.
`timescale 1ns/100ps
`include "mdx_defines.vh"

// Operation
// - Zero flag set when a flag-updating arithmetic result is zero.
// - Carry flag is carry-out on add, borrow on subtract.
// - Half flag reports carry out of the low nibble on add, borrow on subtract.
// - Overflow flag reports signed two's complement range exceeded.
// - Bit access to memory only allowed at addresses 0 to 0x3F.
// - Memory or IO load sets only zero flag; other moves keep flags.
// - Timer word load copies timer count to memory word, flags kept.
// - Timer word store writes memory word into timer count, flags kept.
// - Indirect read loads work register via pointer, two cycles, flags kept.
// - Indirect write stores work register via pointer, two cycles, flags kept.
// - Exchange swaps work register with memory byte, flags kept.
// - Save writes flags and work register at stack pointer, pointer plus two.
// - Restore lowers pointer by two then reloads flags and work register.
// - Plain add with immediate or memory updates all four flags.
// - Add with carry sums memory, work register and carry, all flags.
// - Single-operand add with carry adds carry only, all flags.
// - Negate-add adds two's complement of one operand, all flags.
// - Subtract done as add of two's complement, all flags.
// - Subtract with borrow removes operand and carry, all flags.
// - Single-operand subtract with borrow removes carry only, all flags.
// - Increment and decrement update flags; clear writes zero, flags kept.
// - Multiply 8x8 unsigned, high byte to product register, low to work.
module mdx_exec (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // Command port
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [5:0]  cmd_op,
  input  wire [7:0]  cmd_addr,
  input  wire [7:0]  cmd_imm,
  output reg         cmd_done_q,
  output reg         cmd_err_q,
  // IO register port
  output wire [7:0]  io_raddr,
  input  wire [7:0]  io_rdata,
  output reg         io_we_q,
  output reg  [7:0]  io_waddr_q,
  output reg  [7:0]  io_wdata_q,
  // Sixteen-bit timer port
  input  wire [15:0] tmr_count,
  output reg         tmr_we_q,
  output reg  [15:0] tmr_wdata_q,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_IDX  = 1'b1;

  // flag computation
  // Result layout: [7:0] value, [8] C, [9] AC, [10] OV, [11] Z
  function [11:0] alu;
    input [7:0] a;
    input [7:0] b;
    input       ci;
    input       sub;
    reg   [7:0] bb;
    reg         cin;
    reg   [4:0] lo;
    reg   [8:0] full;
    begin
      bb   = sub ? ~b : b;
      cin  = sub ? ~ci : ci;
      lo   = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
      full = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
      alu[7:0] = full[7:0];
      alu[8]   = sub ? ~full[8] : full[8];
      alu[9]   = sub ? ~lo[4] : lo[4];
      alu[10]  = (a[7] == bb[7]) && (full[7] != a[7]);
      alu[11]  = (full[7:0] == 8'h00);
    end
  endfunction

  // Packs an alu result into the flag register layout
  function [3:0] flg_of;
    input [11:0] r;
    begin
      flg_of = 4'h0;
      flg_of[`MDX_FZ]  = r[11];
      flg_of[`MDX_FC]  = r[8];
      flg_of[`MDX_FAC] = r[9];
      flg_of[`MDX_FOV] = r[10];
    end
  endfunction

  reg  [7:0]  mem [0:`MDX_RAM_DEPTH-1];
  reg  [7:0]  acc_q, acc_d;
  reg  [3:0]  flg_q, flg_d;
  reg  [7:0]  sp_q, sp_d;
  reg  [7:0]  mulop_q;
  reg  [7:0]  mulhi_q, mulhi_d;
  reg         state_q;
  reg         idx_wr_q;
  reg  [6:0]  ptr_q;
  reg         biterr_q;
  reg         operr_q;
  reg         w0_en, w1_en;
  reg  [6:0]  w0_a, w1_a;
  reg  [7:0]  w0_d, w1_d;
  reg  [11:0] r;
  reg  [15:0] prod;
  reg         bad_op, bad_bit;
  reg  [7:0]  bmask;

  wire       take    = cmd_valid & cmd_ready;
  wire [6:0] ad      = cmd_addr[6:0];
  wire [6:0] ad1     = ad + 7'h01;
  wire [7:0] m       = mem[ad];
  wire [7:0] m1      = mem[ad1];
  wire [6:0] sp_lo   = sp_q[6:0];
  wire [7:0] sp_dn   = sp_q - 8'h02;
  wire       cf      = flg_q[`MDX_FC];
  wire       exec_on = take | (state_q == ST_IDX);
  wire       wb_go   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~exec_on;
  wire       wb_wr   = wb_go & wb_we_i & wb_sel_i[0];
  wire       wb_ram  = (wb_adr_i[11:9] == `MDX_RAM_BASE);

  assign cmd_ready = (state_q == ST_IDLE);
  assign io_raddr  = cmd_addr;

  // Next-state datapath for one command
  always @* begin
    acc_d   = acc_q;
    flg_d   = flg_q;
    sp_d    = sp_q;
    mulhi_d = mulhi_q;
    w0_en   = 1'b0;
    w0_a    = ad;
    w0_d    = 8'h00;
    w1_en   = 1'b0;
    w1_a    = ad1;
    w1_d    = 8'h00;
    r       = 12'h000;
    prod    = 16'h0000;
    bad_op  = 1'b0;
    bad_bit = 1'b0;
    bmask   = 8'h01 << cmd_imm[2:0];
    if (take) begin
      case (cmd_op)
        `MDX_OP_MOV_AI: acc_d = cmd_imm;
        `MDX_OP_MOV_MA: begin
          w0_en = 1'b1;
          w0_d  = acc_q;
        end
        `MDX_OP_MOV_AM: begin
          acc_d = m;
          flg_d[`MDX_FZ] = (m == 8'h00);
        end
        `MDX_OP_MOV_AIO: begin
          acc_d = io_rdata;
          flg_d[`MDX_FZ] = (io_rdata == 8'h00);
        end
        `MDX_OP_MOV_IOA: ;
        `MDX_OP_TLOAD: begin
          w0_en = 1'b1;
          w0_d  = tmr_count[7:0];
          w1_en = 1'b1;
          w1_d  = tmr_count[15:8];
        end
        `MDX_OP_TSTORE: ;
        `MDX_OP_IDX_RD: ;
        `MDX_OP_IDX_WR: ;
        `MDX_OP_XCH: begin
          acc_d = m;
          w0_en = 1'b1;
          w0_d  = acc_q;
        end
        `MDX_OP_PUSH: begin
          w0_en = 1'b1;
          w0_a  = sp_lo;
          w0_d  = acc_q;
          w1_en = 1'b1;
          w1_a  = sp_lo + 7'h01;
          w1_d  = {4'h0, flg_q};
          sp_d  = sp_q + 8'h02;
        end
        `MDX_OP_POP: begin
          sp_d  = sp_dn;
          acc_d = mem[sp_dn[6:0]];
          flg_d = mem[sp_dn[6:0] + 7'h01][3:0];
        end
        `MDX_OP_ADD_AI: begin
          r = alu(acc_q, cmd_imm, 1'b0, 1'b0);
          acc_d = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_ADD_AM: begin
          r = alu(acc_q, m, 1'b0, 1'b0);
          acc_d = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_ADD_MA: begin
          r = alu(m, acc_q, 1'b0, 1'b0);
          w0_en = 1'b1;
          w0_d  = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_ADDC_AM: begin
          r = alu(acc_q, m, cf, 1'b0);
          acc_d = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_ADDC_MA: begin
          r = alu(m, acc_q, cf, 1'b0);
          w0_en = 1'b1;
          w0_d  = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_ADDC_A: begin
          r = alu(acc_q, 8'h00, cf, 1'b0);
          acc_d = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_ADDC_M: begin
          r = alu(m, 8'h00, cf, 1'b0);
          w0_en = 1'b1;
          w0_d  = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_NADD_AM: begin
          r = alu(m, acc_q, 1'b0, 1'b1);
          acc_d = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_NADD_MA: begin
          r = alu(acc_q, m, 1'b0, 1'b1);
          w0_en = 1'b1;
          w0_d  = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_SUB_AI: begin
          r = alu(acc_q, cmd_imm, 1'b0, 1'b1);
          acc_d = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_SUB_AM: begin
          r = alu(acc_q, m, 1'b0, 1'b1);
          acc_d = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_SUB_MA: begin
          r = alu(m, acc_q, 1'b0, 1'b1);
          w0_en = 1'b1;
          w0_d  = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_SUBC_AM: begin
          r = alu(acc_q, m, cf, 1'b1);
          acc_d = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_SUBC_MA: begin
          r = alu(m, acc_q, cf, 1'b1);
          w0_en = 1'b1;
          w0_d  = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_SUBC_A: begin
          r = alu(acc_q, 8'h00, cf, 1'b1);
          acc_d = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_SUBC_M: begin
          r = alu(m, 8'h00, cf, 1'b1);
          w0_en = 1'b1;
          w0_d  = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_INC_M: begin
          r = alu(m, 8'h01, 1'b0, 1'b0);
          w0_en = 1'b1;
          w0_d  = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_DEC_M: begin
          r = alu(m, 8'h01, 1'b0, 1'b1);
          w0_en = 1'b1;
          w0_d  = r[7:0];
          flg_d = flg_of(r);
        end
        `MDX_OP_CLR_M: w0_en = 1'b1;
        `MDX_OP_MUL: begin
          prod    = acc_q * mulop_q;
          acc_d   = prod[7:0];
          mulhi_d = prod[15:8];
        end
        `MDX_OP_BCLR_M, `MDX_OP_BSET_M: begin
          if (cmd_addr > `MDX_BIT_ADDR_MAX) begin
            bad_bit = 1'b1;
          end else begin
            w0_en = 1'b1;
            w0_d  = cmd_op[0] ? (m | bmask) : (m & ~bmask);
          end
        end
        default: bad_op = 1'b1;
      endcase
    end else if (state_q == ST_IDX) begin
      if (idx_wr_q) begin
        w0_en = 1'b1;
        w0_a  = ptr_q;
        w0_d  = acc_q;
      end else begin
        acc_d = mem[ptr_q];
      end
    end else if (wb_wr & wb_ram) begin
      w0_en = 1'b1;
      w0_a  = wb_adr_i[8:2];
      w0_d  = wb_dat_i[7:0];
    end
  end

  // Data memory, two byte write ports
  always @(posedge core_clk) begin
    if (w0_en) begin
      mem[w0_a] <= w0_d;
    end
    if (w1_en) begin
      mem[w1_a] <= w1_d;
    end
  end

  // Core state and pulses
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q       <= `MDX_RST_WORK;
      flg_q       <= `MDX_RST_FLAG;
      sp_q        <= `MDX_RST_STACK;
      mulop_q     <= `MDX_RST_MULOP;
      mulhi_q     <= 8'h00;
      state_q     <= ST_IDLE;
      idx_wr_q    <= 1'b0;
      ptr_q       <= 7'h00;
      cmd_done_q  <= 1'b0;
      cmd_err_q   <= 1'b0;
      io_we_q     <= 1'b0;
      io_waddr_q  <= 8'h00;
      io_wdata_q  <= 8'h00;
      tmr_we_q    <= 1'b0;
      tmr_wdata_q <= 16'h0000;
      biterr_q    <= 1'b0;
      operr_q     <= 1'b0;
    end else begin
      acc_d_apply();
    end
  end

  // Register updates shared by command and bus paths
  task acc_d_apply;
    begin
      acc_q      <= acc_d;
      flg_q      <= flg_d;
      sp_q       <= sp_d;
      mulhi_q    <= mulhi_d;
      cmd_err_q  <= bad_op | bad_bit;
      io_we_q    <= take & (cmd_op == `MDX_OP_MOV_IOA);
      tmr_we_q   <= take & (cmd_op == `MDX_OP_TSTORE);
      if (take & (cmd_op == `MDX_OP_TSTORE)) begin
        tmr_wdata_q <= {m1, m};
      end
      if (take & (cmd_op == `MDX_OP_MOV_IOA)) begin
        io_waddr_q <= cmd_addr;
        io_wdata_q <= acc_q;
      end
      if (take & ((cmd_op == `MDX_OP_IDX_RD) | (cmd_op == `MDX_OP_IDX_WR))) begin
        state_q    <= ST_IDX;
        idx_wr_q   <= (cmd_op == `MDX_OP_IDX_WR);
        ptr_q      <= m[6:0];
        cmd_done_q <= 1'b0;
      end else if (state_q == ST_IDX) begin
        state_q    <= ST_IDLE;
        cmd_done_q <= 1'b1;
      end else begin
        cmd_done_q <= take;
      end
      // Bus writes to registers, set beats clear
      if (wb_wr & ~wb_ram) begin
        if (wb_adr_i == `MDX_REG_WORK) begin
          acc_q <= wb_dat_i[7:0];
        end else if (wb_adr_i == `MDX_REG_FLAG) begin
          flg_q <= wb_dat_i[3:0];
        end else if (wb_adr_i == `MDX_REG_STACK) begin
          sp_q <= wb_dat_i[7:0];
        end else if (wb_adr_i == `MDX_REG_MULOP) begin
          mulop_q <= wb_dat_i[7:0];
        end
      end
      biterr_q <= bad_bit | (biterr_q & ~(wb_wr & (wb_adr_i == `MDX_REG_STAT) & wb_dat_i[`MDX_ST_BITERR]));
      operr_q  <= bad_op | (operr_q & ~(wb_wr & (wb_adr_i == `MDX_REG_STAT) & wb_dat_i[`MDX_ST_OPERR]));
    end
  endtask

  // Wishbone answer, one cycle after a request seen while no command is taken or in its indirect cycle
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_go;
      if (wb_go) begin
        if (wb_ram) begin
          wb_dat_o <= {24'h000000, mem[wb_adr_i[8:2]]};
        end else if (wb_adr_i == `MDX_REG_WORK) begin
          wb_dat_o <= {24'h000000, acc_q};
        end else if (wb_adr_i == `MDX_REG_FLAG) begin
          wb_dat_o <= {28'h0000000, flg_q};
        end else if (wb_adr_i == `MDX_REG_STACK) begin
          wb_dat_o <= {24'h000000, sp_q};
        end else if (wb_adr_i == `MDX_REG_MULOP) begin
          wb_dat_o <= {24'h000000, mulop_q};
        end else if (wb_adr_i == `MDX_REG_MULHI) begin
          wb_dat_o <= {24'h000000, mulhi_q};
        end else if (wb_adr_i == `MDX_REG_STAT) begin
          wb_dat_o <= {29'h00000000, operr_q, biterr_q, state_q};
        end else begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

endmodule

// [sim/mdx_exec_assertions.sv]
// Assertions on the command, IO and timer ports of the execution unit.
// Assumes binding onto mdx_exec; one clock, reset active low.
`timescale 1ns/100ps
`include "mdx_defines.vh"
module mdx_exec_assertions (
  // Clock and reset
  input wire       core_clk,
  input wire       rst_b,
  // Command port
  input wire       cmd_valid,
  input wire       cmd_ready,
  input wire [5:0] cmd_op,
  input wire [7:0] cmd_addr,
  input wire       cmd_done_q,
  input wire       cmd_err_q,
  // IO and timer side
  input wire       io_we_q,
  input wire       tmr_we_q
);
  // Taken commands by kind
  wire take    = cmd_valid & cmd_ready;
  wire t_idx   = take & (cmd_op == `MDX_OP_IDX_RD | cmd_op == `MDX_OP_IDX_WR);
  wire t_one   = take & ~t_idx;
  wire t_ts    = take & (cmd_op == `MDX_OP_TSTORE);
  wire t_io    = take & (cmd_op == `MDX_OP_MOV_IOA);
  wire t_bit   = take & (cmd_op == `MDX_OP_BSET_M | cmd_op == `MDX_OP_BCLR_M);
  wire bit_far = cmd_addr > `MDX_BIT_ADDR_MAX;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_one_cycle;
    t_one |=> cmd_done_q && cmd_ready;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("single-cycle command late");
  property p_idx_rd;
    take && cmd_op == `MDX_OP_IDX_RD |=> !cmd_ready && !cmd_done_q ##1 cmd_done_q;
  endproperty
  a_idx_rd: assert property (p_idx_rd) else $error("indirect read not two cycles");
  property p_idx_wr;
    take && cmd_op == `MDX_OP_IDX_WR |=> !cmd_ready && !cmd_done_q ##1 cmd_done_q;
  endproperty
  a_idx_wr: assert property (p_idx_wr) else $error("indirect write not two cycles");
  property p_done_src;
    cmd_done_q |-> $past(t_one) || $past(t_idx, 2);
  endproperty
  a_done_src: assert property (p_done_src) else $error("done without matching command");
  property p_bit_far;
    t_bit && bit_far |=> cmd_err_q && cmd_done_q;
  endproperty
  a_bit_far: assert property (p_bit_far) else $error("bit access above limit accepted");
  property p_bit_near;
    t_bit && !bit_far |=> !cmd_err_q;
  endproperty
  a_bit_near: assert property (p_bit_near) else $error("bit access in range refused");
  property p_tstore;
    t_ts |=> tmr_we_q;
  endproperty
  a_tstore: assert property (p_tstore) else $error("timer store gave no write");
  property p_io_we;
    io_we_q |-> $past(t_io);
  endproperty
  a_io_we: assert property (p_io_we) else $error("IO write without IO store");

  // Main scenarios reached
  c_idx: cover property (t_idx);
  c_far: cover property (t_bit && bit_far);
  c_tstore: cover property (t_ts);
endmodule

bind mdx_exec mdx_exec_assertions mdx_exec_assertions_inst (.core_clk, .rst_b, .cmd_valid, .cmd_ready,
  .cmd_op, .cmd_addr, .cmd_done_q, .cmd_err_q, .io_we_q, .tmr_we_q);

// [sim/mdx_tb.sv]
// Self-checking bench for the data-move and arithmetic execution unit.
// Assumes mdx_exec with its bound checker; registers reached over Wishbone.
`timescale 1ns/100ps
`include "mdx_defines.vh"
module testbench;
  // Design inputs
  reg         core_clk, rst_b, cmd_valid, wb_cyc_i, wb_stb_i, wb_we_i;
  reg  [5:0]  cmd_op;
  reg  [7:0]  cmd_addr, cmd_imm, io_rdata;
  reg  [15:0] tmr_count;
  reg  [11:0] wb_adr_i;
  reg  [3:0]  wb_sel_i;
  reg  [31:0] wb_dat_i;
  // Design outputs
  wire        cmd_ready, cmd_done_q, cmd_err_q, io_we_q, tmr_we_q, wb_ack_o;
  wire [7:0]  io_raddr, io_waddr_q, io_wdata_q;
  wire [15:0] tmr_wdata_q;
  wire [31:0] wb_dat_o;
  // Bench state
  integer     err_total, n_tests;
  reg  [31:0] rv;
  reg  [2:0]  lat;
  reg         s_err, s_io, s_tmr;

  mdx_exec mdx_exec_inst (.core_clk, .rst_b, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_imm,
    .cmd_done_q, .cmd_err_q, .io_raddr, .io_rdata, .io_we_q, .io_waddr_q, .io_wdata_q, .tmr_count,
    .tmr_we_q, .tmr_wdata_q, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o);

  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Compare and count
  task chk(input [63:0] what, input [15:0] seen, exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A wait that ran out
  task hang(input [63:0] what);
    err_total = err_total + 1;
    $display("MISMATCH %0s expected answer seen none", what);
    close_out;
  endtask

  // Classic Wishbone cycle held until ack
  task wb(input we, input [11:0] adr, input [7:0] d);
    integer n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n = n + 1;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
      hang("wb_ack");
    rv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Byte address of a data memory cell
  function [11:0] ra(input [7:0] i);
    ra = 12'h200 + {3'h0, i[6:0], 2'h0};
  endfunction

  // One command: wait for take, then for done
  task cmd(input [5:0] op, input [7:0] ad, im);
    integer n;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_addr  <= ad;
    cmd_imm   <= im;
    n = 0;
    do begin
      @(posedge core_clk);
      n = n + 1;
    end while (cmd_ready !== 1'b1 && n < 50);
    cmd_valid <= 1'b0;
    lat = 3'h0;
    do begin
      @(posedge core_clk);
      lat = lat + 3'h1;
    end while (cmd_done_q !== 1'b1 && lat < 3'h6);
    if (cmd_done_q !== 1'b1)
      hang("done");
    s_err = cmd_err_q;
    s_io  = io_we_q;
    s_tmr = tmr_we_q;
  endtask

  // Preload memory byte, flags and work register
  task setup(input [7:0] a, m, input [3:0] f, input [7:0] ad);
    wb(1'b1, ra(ad), m);
    wb(1'b1, `MDX_REG_FLAG, {4'h0, f});
    cmd(`MDX_OP_MOV_AI, 8'h00, a);
  endtask

  // Read back work, flags and one memory byte
  task see(input [7:0] w, input [3:0] f, input [7:0] ad, m);
    wb(1'b0, `MDX_REG_WORK, 8'h00);
    chk("work", rv[15:0], {8'h00, w});
    wb(1'b0, `MDX_REG_FLAG, 8'h00);
    chk("flags", rv[15:0], {12'h000, f});
    wb(1'b0, ra(ad), 8'h00);
    chk("mem", rv[15:0], {8'h00, m});
  endtask

  // flag model, gives {result, ov, ac, c, z}
  function [11:0] alu(input [7:0] a, b, input ci, sb);
    reg [7:0] y;
    reg [8:0] s;
    reg [4:0] h;
    y = sb ? ~b : b;
    s = a + y + (ci ^ sb);
    h = a[3:0] + y[3:0] + (ci ^ sb);
    alu = {s[7:0], a[7] == y[7] && s[7] != a[7], h[4] ^ sb, s[8] ^ sb, s[7:0] == 8'h00};
  endfunction

  // Every arithmetic code except multiply over four operand sets
  task t_arith;
    reg [7:0]  a, m, i;
    reg [11:0] r;
    reg [6:0]  op;
    reg        c, dm;
    integer    v;
    for (v = 0; v < 4; v = v + 1) begin
      for (op = `MDX_OP_ADD_AI; op <= `MDX_OP_CLR_M; op = op + 7'h01) begin
        {a, m, i} = v == 0 ? 24'h887878 : v == 1 ? 24'h7f0101 : v == 2 ? 24'h3c5ac4 : 24'h8001ff;
        c = ~v[0];
        case (op[5:0])
          `MDX_OP_ADD_AI:  r = alu(a, i, 1'b0, 1'b0);
          `MDX_OP_ADD_AM,
          `MDX_OP_ADD_MA:  r = alu(a, m, 1'b0, 1'b0);
          `MDX_OP_ADDC_AM,
          `MDX_OP_ADDC_MA: r = alu(a, m, c, 1'b0);
          `MDX_OP_ADDC_A:  r = alu(a, 8'h00, c, 1'b0);
          `MDX_OP_ADDC_M:  r = alu(m, 8'h00, c, 1'b0);
          `MDX_OP_NADD_AM,
          `MDX_OP_SUB_MA:  r = alu(m, a, 1'b0, 1'b1);
          `MDX_OP_NADD_MA,
          `MDX_OP_SUB_AM:  r = alu(a, m, 1'b0, 1'b1);
          `MDX_OP_SUB_AI:  r = alu(a, i, 1'b0, 1'b1);
          `MDX_OP_SUBC_AM: r = alu(a, m, c, 1'b1);
          `MDX_OP_SUBC_MA: r = alu(m, a, c, 1'b1);
          `MDX_OP_SUBC_A:  r = alu(a, 8'h00, c, 1'b1);
          `MDX_OP_SUBC_M:  r = alu(m, 8'h00, c, 1'b1);
          `MDX_OP_INC_M:   r = alu(m, 8'h01, 1'b0, 1'b0);
          `MDX_OP_DEC_M:   r = alu(m, 8'h01, 1'b0, 1'b1);
          default:         r = {8'h00, ~c, c, c, ~c};
        endcase
        dm = op[5:0] inside {`MDX_OP_ADD_MA, `MDX_OP_ADDC_MA, `MDX_OP_ADDC_M, `MDX_OP_NADD_MA,
          `MDX_OP_SUB_MA, `MDX_OP_SUBC_MA, `MDX_OP_SUBC_M, `MDX_OP_INC_M, `MDX_OP_DEC_M, `MDX_OP_CLR_M};
        setup(a, m, {~c, c, c, ~c}, 8'h45);
        cmd(op[5:0], 8'h45, i);
        see(dm ? a : r[11:4], r[3:0], 8'h45, dm ? r[11:4] : m);
      end
    end
  endtask

  // Moves, exchange, timer words, indirect, stack, multiply, bit reach
  task t_moves;
    setup(8'h11, 8'h00, 4'he, 8'h30);
    cmd(`MDX_OP_MOV_AM, 8'h30, 8'h00);
    see(8'h00, 4'hf, 8'h30, 8'h00);
    io_rdata <= 8'h5a;
    cmd(`MDX_OP_MOV_AIO, 8'h21, 8'h00);
    chk("io_raddr", {8'h00, io_raddr}, 16'h0021);
    cmd(`MDX_OP_MOV_IOA, 8'h22, 8'h00);
    chk("io_out", {io_waddr_q, io_wdata_q}, 16'h225a);
    chk("io_we", s_io, 1'b1);
    cmd(`MDX_OP_MOV_MA, 8'h31, 8'h00);
    see(8'h5a, 4'he, 8'h31, 8'h5a);
    cmd(`MDX_OP_XCH, 8'h30, 8'h00);
    see(8'h00, 4'he, 8'h30, 8'h5a);
    tmr_count <= 16'hbeef;
    cmd(`MDX_OP_TLOAD, 8'h7f, 8'h00);
    see(8'h00, 4'he, 8'h00, 8'hbe);
    wb(1'b1, ra(8'h40), 8'h34);
    wb(1'b1, ra(8'h41), 8'h12);
    cmd(`MDX_OP_TSTORE, 8'h40, 8'h00);
    chk("tmr_out", tmr_wdata_q, 16'h1234);
    chk("tmr_we", s_tmr, 1'b1);
    wb(1'b1, ra(8'h50), 8'h5b);
    wb(1'b1, ra(8'h5b), 8'ha5);
    cmd(`MDX_OP_IDX_RD, 8'h50, 8'h00);
    chk("idx_lat", lat, 3'h2);
    see(8'ha5, 4'he, 8'h7f, 8'hef);
    cmd(`MDX_OP_MOV_AI, 8'h00, 8'h3c);
    cmd(`MDX_OP_IDX_WR, 8'h50, 8'h00);
    chk("idx_lat", lat, 3'h2);
    see(8'h3c, 4'he, 8'h5b, 8'h3c);
    wb(1'b1, `MDX_REG_STACK, 8'h20);
    cmd(`MDX_OP_PUSH, 8'h00, 8'h00);
    see(8'h3c, 4'he, 8'h21, 8'h0e);
    wb(1'b0, `MDX_REG_STACK, 8'h00);
    chk("stack", rv[15:0], 16'h0022);
    setup(8'h77, 8'h00, 4'h1, 8'h60);
    cmd(`MDX_OP_POP, 8'h00, 8'h00);
    see(8'h3c, 4'he, 8'h20, 8'h3c);
    wb(1'b0, `MDX_REG_STACK, 8'h00);
    chk("stack", rv[15:0], 16'h0020);
    wb(1'b1, `MDX_REG_MULOP, 8'h5a);
    cmd(`MDX_OP_MOV_AI, 8'h00, 8'ha5);
    cmd(`MDX_OP_MUL, 8'h00, 8'h00);
    wb(1'b0, `MDX_REG_MULHI, 8'h00);
    chk("mul_hi", rv[15:0], 16'h003a);
    // bit reach ends at the limit
    wb(1'b1, ra(8'h3f), 8'h00);
    cmd(`MDX_OP_BSET_M, 8'h3f, 8'h07);
    chk("bit_err", s_err, 1'b0);
    cmd(`MDX_OP_BSET_M, 8'h40, 8'h07);
    chk("bit_err", s_err, 1'b1);
    see(8'h02, 4'he, 8'h3f, 8'h80);
    wb(1'b0, 12'h018, 8'h00);
    chk("unmapped", rv[15:0], 16'h0000);
    cmd(`MDX_OP_BCLR_M, 8'h3f, 8'h07);
    wb(1'b0, ra(8'h3f), 8'h00);
    chk("bit_clr", rv[15:0], 16'h0000);
    cmd(6'h3f, 8'h00, 8'h00);
    chk("op_err", s_err, 1'b1);
    wb(1'b0, `MDX_REG_STAT, 8'h00);
    chk("status", rv[15:0], 16'h0006);
    wb(1'b1, `MDX_REG_STAT, 8'h06);
    wb(1'b0, `MDX_REG_STAT, 8'h00);
    chk("status", rv[15:0], 16'h0000);
  endtask

  // Reset, scenarios, verdict
  initial begin
    err_total = 0;
    n_tests = 0;
    rst_b = 1'b0;
    {cmd_valid, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    {cmd_op, cmd_addr, cmd_imm, io_rdata} = 30'h0;
    {tmr_count, wb_adr_i, wb_dat_i} = 60'h0;
    wb_sel_i = 4'h1;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    t_arith;
    t_moves;
    close_out;
  end
endmodule
